// ### design/tgr_pkg.sv
// constants, enumerations and carriers shared by the target responder
// assumes a completer-request stream laid out as a 128-bit descriptor followed by payload
package tgr_pkg;

  // datapath variants of the request and completion streams
  typedef enum logic [1:0] {
    NARROW_DATAPATH_VARIANT = 2'h0,
    MIDDLE_DATAPATH_VARIANT = 2'h1,
    WIDE_DATAPATH_VARIANT   = 2'h2
  } tgr_variant_t;

  localparam int NARROW_W = 64;
  localparam int MIDDLE_W = 128;
  localparam int WIDE_W   = 256;

  // request descriptor field positions
  localparam int ADDR_LSB  = 2;
  localparam int LADDR_W   = 7;
  localparam int DWCNT_LSB = 64;
  localparam int KIND_LSB  = 75;
  localparam int REQID_LSB = 80;
  localparam int TAG_LSB   = 96;
  localparam int HIT_LSB   = 112;
  localparam int TC_LSB    = 121;
  localparam int ATTR_LSB  = 124;
  localparam int DATA_LSB  = 128;
  localparam int CAP_W     = 160;

  // completion descriptor field positions
  localparam int CC_LADDR_LSB = 0;
  localparam int CC_BCNT_LSB  = 16;
  localparam int CC_DWCNT_LSB = 32;
  localparam int CC_REQID_LSB = 48;
  localparam int CC_TAG_LSB   = 64;
  localparam int CC_TC_LSB    = 89;
  localparam int CC_ATTR_LSB  = 92;
  localparam int CC_DATA_LSB  = 96;
  localparam int CPL_W        = 256;
  localparam int CPL_DATA_DW   = 4;
  localparam int CPL_NODATA_DW = 3;
  localparam logic [12:0] CPL_BYTE_CNT = 13'h0004;
  localparam logic [10:0] ONE_DWORD    = 11'h001;

  // request kinds
  localparam logic [3:0] KIND_MEM_RD = 4'h0;
  localparam logic [3:0] KIND_MEM_WR = 4'h1;
  localparam logic [3:0] KIND_IO_RD  = 4'h2;
  localparam logic [3:0] KIND_IO_WR  = 4'h3;

  // window hit codes and the RAM each one selects
  localparam logic [2:0] HIT_FIRST = 3'h0;
  localparam logic [2:0] HIT_WIDE  = 3'h1;
  localparam logic [2:0] HIT_LOW   = 3'h2;
  localparam logic [2:0] HIT_ROM   = 3'h6;
  localparam logic [1:0] FIRST_WINDOW_RAM       = 2'h0;
  localparam logic [1:0] WIDE_MEMORY_WINDOW_RAM = 2'h1;
  localparam logic [1:0] LOW_MEMORY_WINDOW_RAM  = 2'h2;
  localparam logic [1:0] OPTION_ROM_WINDOW_RAM  = 2'h3;
  localparam int RAM_COUNT = 4;
  localparam int RAM_AW    = 9;
  localparam int RAM_DEPTH = 512;
  localparam int FIFO_DEPTH = 8;

  // one-hot receive/transmit sequencer states
  typedef enum logic [5:0] {
    S_COLLECT = 6'h01,
    S_DECIDE  = 6'h02,
    S_WRITE   = 6'h04,
    S_READ    = 6'h08,
    S_EMIT    = 6'h10,
    S_SENT    = 6'h20
  } tgr_state_t;

  // decoded request as carried from receive to memory and transmit
  typedef struct packed {
    logic [2:0]        hit;
    logic [3:0]        kind;
    logic [10:0]       dw_cnt;
    logic [RAM_AW-1:0] dw_addr;
    logic [6:0]        low_addr;
    logic [15:0]       req_id;
    logic [7:0]        tag;
    logic [2:0]        tc;
    logic [2:0]        attr;
    logic [31:0]       data;
  } tgr_req_t;

  function automatic int tgr_width(tgr_variant_t v);
    case (v)
      MIDDLE_DATAPATH_VARIANT: return MIDDLE_W;
      WIDE_DATAPATH_VARIANT:   return WIDE_W;
      default:                 return NARROW_W;
    endcase
  endfunction

  function automatic logic [1:0] tgr_ram_sel(logic [2:0] hit);
    case (hit)
      HIT_WIDE: return WIDE_MEMORY_WINDOW_RAM;
      HIT_LOW:  return LOW_MEMORY_WINDOW_RAM;
      HIT_ROM:  return OPTION_ROM_WINDOW_RAM;
      default:  return FIRST_WINDOW_RAM;
    endcase
  endfunction

endpackage

// ### design/tgr_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock; full and empty derive from wrapped pointers
`timescale 1ns/1ps
module tgr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;

  assign in_ready  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // tgr_fifo

// ### design/tgr_window_ram.sv
// one 2 KB window store, 512 dwords, registered read
// assumes the caller never reads and writes in the same cycle
`timescale 1ns/1ps
module tgr_window_ram (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // access
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  input  wire logic [tgr_pkg::RAM_AW-1:0] addr,
  input  wire logic [31:0]               wr_data,
  output logic [31:0]                    rd_data
);
  logic [31:0] mem [tgr_pkg::RAM_DEPTH];

  // byte enables are not honoured: whole dword stores only
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= mem[addr];
    end
  end
endmodule // tgr_window_ram

// ### design/tgr_responder.sv
// target-only completer: serves single-dword memory and I/O requests from four window RAMs
// assumes the endpoint core has already matched the window and delivers its hit code
// Overview of operation
// RULE1 - serve one I/O, one 32-bit, one 64-bit and the option ROM window; other windows get nothing
// RULE2 - each window is 2 KB; larger apertures wrap onto it
// RULE3 - I/O window off by default, enabled by configuration input
// RULE4 - multi-dword requests are fully accepted, discarded, never completed
// RULE5 - an accepted I/O write gets a completion without data
// RULE6 - writes extract low address and payload for the RAM write
// RULE7 - hit code chooses the written RAM before write enable rises
// RULE8 - hit code 000b selects the first RAM, the I/O window
// RULE9 - hit code 010b selects the 32-bit memory RAM
// RULE10 - request ready stays low while a write is stored
// RULE11 - hit code chooses the read RAM before read enable rises
// RULE12 - request ready stays low until read done and completion made
// RULE13 - each accepted read is answered with a completion with data
// RULE14 - ready drops right after the last beat of a read
// RULE15 - next read waits until previous completion has been sent
// RULE16 - next write waits until the write-busy indication clears
// RULE17 - buildable with 64, 128 or 256-bit streams
// RULE18 - hit code 001b selects the 64-bit memory RAM
// RULE19 - hit code 110b selects the option ROM RAM
// RULE20 - a read completion carries exactly one dword
// RULE21 - single-dword writes store payload at addressed RAM location
// RULE22 - memory writes are posted: no completion
// RULE23 - RAM indexed by byte address bits above bit 1, higher bits ignored
`timescale 1ns/1ps
module tgr_responder #(
  parameter tgr_pkg::tgr_variant_t VARIANT = tgr_pkg::NARROW_DATAPATH_VARIANT,
  localparam int DW = tgr_pkg::tgr_width(VARIANT),
  localparam int KW = DW / 32
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // configuration
  input  wire logic          io_window_en,
  // completer request stream
  input  wire logic [DW-1:0] cq_tdata,
  input  wire logic          cq_tvalid,
  input  wire logic          cq_tlast,
  output logic               request_stream_ready,
  // completion stream
  output logic [DW-1:0]      cc_tdata,
  output logic [KW-1:0]      cc_tkeep,
  output logic               cc_tlast,
  output logic               cc_tvalid,
  input  wire logic          cc_tready
);
  localparam int FW = DW + KW + 1;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  tgr_pkg::tgr_state_t   state_q;
  tgr_pkg::tgr_state_t   state_d;
  tgr_pkg::tgr_req_t     req_q;
  logic [tgr_pkg::CAP_W-1:0] cap_q;
  logic [tgr_pkg::CAP_W-1:0] cap_d;
  logic [2:0]            beat_q;
  logic [1:0]            emit_q;
  logic                  ready_q;
  logic                  accept;
  logic                  accept_last;
  logic                  is_rd;
  logic                  is_wr;
  logic                  is_io;
  logic                  serve;
  logic [1:0]            sel;
  logic [tgr_pkg::RAM_COUNT-1:0] wr_en;
  logic [tgr_pkg::RAM_COUNT-1:0] rd_en;
  logic [31:0]           rd_data [tgr_pkg::RAM_COUNT];
  logic [tgr_pkg::CPL_W-1:0] cpl;
  int                    tot_dw;
  logic [KW-1:0]         keep;
  logic                  emit_last;
  logic                  f_in_valid;
  logic                  f_in_ready;
  logic [FW-1:0]         f_in_data;
  logic                  f_out_valid;
  logic                  f_out_ready;
  logic [FW-1:0]         f_out_data;
  logic                  tx_idle;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic tgr_pkg::tgr_req_t unpack(input logic [tgr_pkg::CAP_W-1:0] c);
    tgr_pkg::tgr_req_t r;
    r          = '0;
    r.hit      = c[tgr_pkg::HIT_LSB +: $bits(r.hit)];
    r.kind     = c[tgr_pkg::KIND_LSB +: $bits(r.kind)];
    r.dw_cnt   = c[tgr_pkg::DWCNT_LSB +: $bits(r.dw_cnt)];
    r.dw_addr  = c[tgr_pkg::ADDR_LSB +: tgr_pkg::RAM_AW];
    r.low_addr = {c[tgr_pkg::LADDR_W-1:tgr_pkg::ADDR_LSB], {tgr_pkg::ADDR_LSB{1'b0}}};
    r.req_id   = c[tgr_pkg::REQID_LSB +: $bits(r.req_id)];
    r.tag      = c[tgr_pkg::TAG_LSB +: $bits(r.tag)];
    r.tc       = c[tgr_pkg::TC_LSB +: $bits(r.tc)];
    r.attr     = c[tgr_pkg::ATTR_LSB +: $bits(r.attr)];
    r.data     = c[tgr_pkg::DATA_LSB +: $bits(r.data)];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request capture

  assign accept      = ready_q && cq_tvalid;
  assign accept_last = accept && cq_tlast;

  // beats are laid end to end; only the descriptor and first dword are kept
  always_comb
  begin
    cap_d = (beat_q == 3'h0) ? '0 : cap_q;
    for (int i = 0; i < tgr_pkg::CAP_W; i++)
    begin
      if (i >= int'(beat_q) * DW && i < (int'(beat_q) + 1) * DW)
      begin
        cap_d[i] = cq_tdata[(i - int'(beat_q) * DW) % DW];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_q  <= '0;
      beat_q <= 3'h0;
    end
    else if (accept)
    begin
      cap_q <= cap_d;
      if (cq_tlast)
      begin
        beat_q <= 3'h0;
      end
      else if (beat_q != 3'h7)
      begin
        beat_q <= beat_q + 3'h1;
      end
    end
  end

  // every beat is taken even for long requests, so the core never stalls on them
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_q <= '0;
    end
    else if (accept_last)
    begin
      req_q <= unpack(cap_d); // [RULE6] [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign is_rd = (req_q.kind == tgr_pkg::KIND_MEM_RD) || (req_q.kind == tgr_pkg::KIND_IO_RD);
  assign is_wr = (req_q.kind == tgr_pkg::KIND_MEM_WR) || (req_q.kind == tgr_pkg::KIND_IO_WR);
  assign is_io = (req_q.kind == tgr_pkg::KIND_IO_RD) || (req_q.kind == tgr_pkg::KIND_IO_WR);
  assign sel   = tgr_pkg::tgr_ram_sel(req_q.hit); // [RULE7] [RULE8] [RULE9] [RULE11] [RULE18] [RULE19]

  // I/O only through the first window and only when enabled; unknown codes are dropped
  always_comb
  begin
    if (req_q.dw_cnt != tgr_pkg::ONE_DWORD)
    begin
      serve = 1'b0; // [RULE4]
    end
    else if (is_io)
    begin
      serve = io_window_en && (req_q.hit == tgr_pkg::HIT_FIRST); // [RULE1] [RULE3]
    end
    else
    begin
      case (req_q.hit)
        tgr_pkg::HIT_FIRST,
        tgr_pkg::HIT_WIDE,
        tgr_pkg::HIT_LOW,
        tgr_pkg::HIT_ROM: serve = 1'b1;
        default:          serve = 1'b0; // [RULE1]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign tx_idle = !f_out_valid && !cc_tvalid;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tgr_pkg::S_COLLECT:
      begin
        if (accept_last)
        begin
          state_d = tgr_pkg::S_DECIDE;
        end
      end
      tgr_pkg::S_DECIDE:
      begin
        if (serve && is_wr)
        begin
          state_d = tgr_pkg::S_WRITE;
        end
        else if (serve && is_rd)
        begin
          state_d = tgr_pkg::S_READ;
        end
        else
        begin
          state_d = tgr_pkg::S_COLLECT;
        end
      end
      tgr_pkg::S_WRITE:
      begin
        // memory writes are posted; I/O writes owe a completion
        state_d = is_io ? tgr_pkg::S_EMIT : tgr_pkg::S_COLLECT; // [RULE5] [RULE22] [RULE16]
      end
      tgr_pkg::S_READ:
      begin
        state_d = tgr_pkg::S_EMIT; // [RULE13]
      end
      tgr_pkg::S_EMIT:
      begin
        if (f_in_ready && emit_last)
        begin
          state_d = tgr_pkg::S_SENT;
        end
      end
      tgr_pkg::S_SENT:
      begin
        if (tx_idle)
        begin
          state_d = tgr_pkg::S_COLLECT; // [RULE15]
        end
      end
      default:
      begin
        state_d = tgr_pkg::S_COLLECT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= tgr_pkg::S_COLLECT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ready is a flop, so it falls the cycle after the last beat is taken
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= state_d == tgr_pkg::S_COLLECT; // [RULE10] [RULE12] [RULE14]
    end
  end

  assign request_stream_ready = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // window RAMs

  // address bits above the window size are dropped, so wide apertures wrap
  for (genvar g = 0; g < tgr_pkg::RAM_COUNT; g++)
  begin : g_ram
    assign wr_en[g] = (state_q == tgr_pkg::S_WRITE) && (sel == 2'(g)); // [RULE7] [RULE21]
    assign rd_en[g] = (state_q == tgr_pkg::S_READ) && (sel == 2'(g)); // [RULE11]

    tgr_window_ram u_ram (
      .clk     (clk),
      .rstn    (rstn),
      .wr_en   (wr_en[g]),
      .rd_en   (rd_en[g]),
      .addr    (req_q.dw_addr), // [RULE2] [RULE23]
      .wr_data (req_q.data),
      .rd_data (rd_data[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion build and emit

  always_comb
  begin
    cpl = '0;
    cpl[tgr_pkg::CC_LADDR_LSB +: tgr_pkg::LADDR_W] = is_io ? '0 : req_q.low_addr;
    cpl[tgr_pkg::CC_BCNT_LSB +: $bits(tgr_pkg::CPL_BYTE_CNT)] = tgr_pkg::CPL_BYTE_CNT;
    if (is_rd)
    begin
      cpl[tgr_pkg::CC_DWCNT_LSB +: $bits(req_q.dw_cnt)] = tgr_pkg::ONE_DWORD; // [RULE20]
      cpl[tgr_pkg::CC_DATA_LSB +: $bits(req_q.data)] = rd_data[sel]; // [RULE13]
    end
    cpl[tgr_pkg::CC_REQID_LSB +: $bits(req_q.req_id)] = req_q.req_id;
    cpl[tgr_pkg::CC_TAG_LSB +: $bits(req_q.tag)] = req_q.tag;
    cpl[tgr_pkg::CC_TC_LSB +: $bits(req_q.tc)] = req_q.tc;
    cpl[tgr_pkg::CC_ATTR_LSB +: $bits(req_q.attr)] = req_q.attr;
  end

  // status field stays zero: successful completion
  always_comb
  begin
    tot_dw    = is_rd ? tgr_pkg::CPL_DATA_DW : tgr_pkg::CPL_NODATA_DW; // [RULE5]
    emit_last = (int'(emit_q) + 1) * KW >= tot_dw;
    for (int i = 0; i < KW; i++)
    begin
      keep[i] = (int'(emit_q) * KW + i) < tot_dw;
    end
  end

  assign f_in_valid = state_q == tgr_pkg::S_EMIT;
  assign f_in_data  = {emit_last, keep, DW'(cpl >> (int'(emit_q) * DW))};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      emit_q <= 2'h0;
    end
    else if (f_in_valid && f_in_ready)
    begin
      emit_q <= emit_last ? 2'h0 : emit_q + 2'h1;
    end
  end

  // full FIFO stalls the emit state and so, in turn, the request stream
  tgr_fifo #(
    .W     (FW),
    .DEPTH (tgr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // completion output register

  assign f_out_ready = !cc_tvalid || cc_tready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cc_tvalid <= 1'b0;
      cc_tdata  <= '0;
      cc_tkeep  <= '0;
      cc_tlast  <= 1'b0;
    end
    else if (f_out_ready)
    begin
      cc_tvalid <= f_out_valid;
      if (f_out_valid)
      begin
        {cc_tlast, cc_tkeep, cc_tdata} <= f_out_data;
      end
    end
  end

endmodule // tgr_responder

// ### tb/tgr_responder_sva.sv
// assertions on the responder's stream ports, bound into every instance
// assumes a 128-bit or wider variant so a whole descriptor fits one beat
`timescale 1ns/1ps
module tgr_responder_chk #(
  parameter tgr_pkg::tgr_variant_t VARIANT = tgr_pkg::MIDDLE_DATAPATH_VARIANT,
  localparam int DW = tgr_pkg::tgr_width(VARIANT),
  localparam int KW = DW / 32
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rstn,
  // request side
  input wire logic          io_window_en,
  input wire logic [DW-1:0] cq_tdata,
  input wire logic          cq_tvalid,
  input wire logic          cq_tlast,
  input wire logic          request_stream_ready,
  // completion side
  input wire logic [DW-1:0] cc_tdata,
  input wire logic [KW-1:0] cc_tkeep,
  input wire logic          cc_tlast,
  input wire logic          cc_tvalid,
  input wire logic          cc_tready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // descriptor rides in the first beat; later beats carry payload only
  logic         first_q;
  logic [127:0] desc_q;
  logic [127:0] desc;
  logic         take, done, one, hit_ok, rd_ok, no_cpl;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      first_q <= 1'b1;
    else if (take)
      first_q <= cq_tlast;
  end
  always_ff @(posedge clk)
  begin
    if (take && first_q)
      desc_q <= cq_tdata[127:0];
  end
  assign take   = cq_tvalid && request_stream_ready;
  assign done   = take && cq_tlast;
  assign desc   = first_q ? cq_tdata[127:0] : desc_q;
  assign one    = desc[74:64] == tgr_pkg::ONE_DWORD;
  assign hit_ok = desc[114:112] inside {3'h0, 3'h1, 3'h2, 3'h6};
  assign rd_ok  = one && hit_ok && (desc[78:75] == tgr_pkg::KIND_MEM_RD ||
                  (desc[78:75] == tgr_pkg::KIND_IO_RD && desc[114:112] == 3'h0 && io_window_en));
  assign no_cpl = !one || !hit_ok || desc[78:75] == tgr_pkg::KIND_MEM_WR;
  ////////////////////////////////////////
  property p_ready_drop;
    // discarded requests give ready back after one cycle, so only served ones hold it two
    done && (rd_ok || (one && hit_ok && desc[78:75] == tgr_pkg::KIND_MEM_WR)) |=>
      !request_stream_ready [*2];
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready not dropped after last beat");
  property p_busy_cpl;
    cc_tvalid |-> !request_stream_ready;
  endproperty
  a_busy_cpl: assert property (p_busy_cpl) else $error("request taken while completion pending");
  property p_post_wr;
    done && one && hit_ok && desc[78:75] == tgr_pkg::KIND_MEM_WR |=>
      !request_stream_ready ##1 !request_stream_ready ##1 request_stream_ready;
  endproperty
  a_post_wr: assert property (p_post_wr) else $error("posted write ready timing wrong");
  property p_discard_back;
    done && !one |=> !request_stream_ready ##1 request_stream_ready;
  endproperty
  a_discard_back: assert property (p_discard_back) else $error("discarded request stalled");
  property p_rd_cpl;
    done && rd_ok |-> ##[5:8] cc_tvalid;
  endproperty
  a_rd_cpl: assert property (p_rd_cpl) else $error("read without completion");
  property p_rd_shape;
    cc_tvalid && cc_tdata[42:32] == tgr_pkg::ONE_DWORD |->
      cc_tkeep == KW'(4'hF) && cc_tlast && cc_tdata[28:16] == tgr_pkg::CPL_BYTE_CNT;
  endproperty
  a_rd_shape: assert property (p_rd_shape) else $error("read completion shape wrong");
  property p_io_cpl;
    cc_tvalid && cc_tdata[42:32] == 11'h000 |-> cc_tkeep == KW'(4'h7) && cc_tlast;
  endproperty
  a_io_cpl: assert property (p_io_cpl) else $error("dataless completion shape wrong");
  property p_no_cpl;
    // a read may follow two cycles later and show its completion five after that
    done && no_cpl |=> !cc_tvalid [*6];
  endproperty
  a_no_cpl: assert property (p_no_cpl) else $error("completion for silent request");
  property p_cc_hold;
    cc_tvalid && !cc_tready |=> cc_tvalid && $stable(cc_tdata) && $stable(cc_tkeep);
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("completion changed while stalled");
  c_read: cover property (done && rd_ok);
  c_post: cover property (done && one && desc[78:75] == tgr_pkg::KIND_MEM_WR);
  c_stall: cover property (cc_tvalid && !cc_tready);
endmodule // tgr_responder_chk

bind tgr_responder tgr_responder_chk #(.VARIANT(VARIANT)) chk_u (.clk, .rstn, .io_window_en, .cq_tdata,
  .cq_tvalid, .cq_tlast, .request_stream_ready, .cc_tdata, .cc_tkeep, .cc_tlast, .cc_tvalid, .cc_tready);

// ### tb/tgr_core_model.sv
// completion sink standing in for the endpoint core's transmit side
// assumes the responder holds its completion steady until taken
`timescale 1ns/1ps
module tgr_core_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // completion stream
  input  wire logic cc_tvalid,
  output logic      cc_tready,
  // stall control
  input  wire logic slow
);
  integer seed = 32'h0E216D35;
  // slow mode takes roughly one beat in four to stress the hold rule
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cc_tready <= 1'b0;
    else
      cc_tready <= !slow || (($random(seed) & 3) == 0);
  end
endmodule // tgr_core_model

// ### tb/tb_top.sv
// self-checking bench for the target responder, 128-bit variant
// assumes one 40 MHz clock and the core model as completion sink
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [31:0] data; logic [10:0] dwc; logic [7:0] tag; logic [3:0] keep;} tgr_exp_t;
  localparam logic [2:0] HITS [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  logic         clk = 1'b0, rstn = 1'b0, io_window_en = 1'b0, slow = 1'b0;
  logic         cq_tvalid = 1'b0, cq_tlast = 1'b0;
  logic [127:0] cq_tdata = '0;
  logic [127:0] cc_tdata;
  logic [3:0]   cc_tkeep;
  logic         request_stream_ready, cc_tlast, cc_tvalid, cc_tready;
  logic [31:0]  mem [4][512];
  logic [63:0]  at [4];
  logic [7:0]   tag_q = 8'h00;
  tgr_exp_t     expq [$];
  tgr_exp_t     mon_e;
  integer       seed = 32'h0E216D35;
  int           bad_count = 0, samples_checked = 0, k, n;
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  tgr_responder #(.VARIANT(tgr_pkg::MIDDLE_DATAPATH_VARIANT)) dut_u (.clk(clk), .rstn(rstn),
    .io_window_en(io_window_en), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid), .cq_tlast(cq_tlast),
    .request_stream_ready(request_stream_ready), .cc_tdata(cc_tdata), .cc_tkeep(cc_tkeep),
    .cc_tlast(cc_tlast), .cc_tvalid(cc_tvalid), .cc_tready(cc_tready));
  tgr_core_model core_u (.clk(clk), .rstn(rstn), .cc_tvalid(cc_tvalid), .cc_tready(cc_tready), .slow(slow));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one request, beats low first; each beat held until ready is sampled high
  task automatic req(input logic [3:0] kind, input logic [2:0] hit, input logic [63:0] addr,
                     input logic [10:0] dwc, input logic [31:0] d, input int beats);
    logic [383:0] v;
    int w;
    @(posedge clk);
    v = '0;
    v[63:0] = addr;
    v[tgr_pkg::DWCNT_LSB +: 11] = dwc;
    v[tgr_pkg::KIND_LSB +: 4] = kind;
    v[tgr_pkg::REQID_LSB +: 16] = 16'($random(seed));
    v[tgr_pkg::TAG_LSB +: 8] = tag_q;
    v[tgr_pkg::HIT_LSB +: 3] = hit;
    v[tgr_pkg::DATA_LSB +: 32] = d;
    for (int b = 0; b < beats; b++)
    begin
      cq_tvalid <= 1'b1;
      cq_tlast  <= (b == beats - 1);
      cq_tdata  <= v[b*128 +: 128];
      w = 0;
      @(posedge clk);
      while (request_stream_ready !== 1'b1 && w < 200)
      begin
        w++;
        @(posedge clk);
      end
      if (w == 200)
        check(32'h0, 32'h1);
    end
    cq_tvalid <= 1'b0;
    cq_tlast  <= 1'b0;
    cq_tdata  <= ~cq_tdata;
    tag_q++;
  endtask
  task automatic wr(input logic [3:0] kind, input int r, input logic [63:0] addr, input logic [31:0] d);
    mem[r][addr[10:2]] = d;
    req(kind, HITS[r], addr, 11'h001, d, 2);
  endtask
  task automatic rd(input logic [3:0] kind, input int r, input logic [63:0] addr);
    expq.push_back('{mem[r][addr[10:2]], 11'h001, tag_q, 4'hF});
    req(kind, HITS[r], addr, 11'h001, 32'h0, 1);
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rstn && cc_tvalid === 1'b1 && cc_tready === 1'b1)
    begin
      if (expq.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        mon_e = expq.pop_front();
        check(32'(cc_tdata[42:32]), 32'(mon_e.dwc));
        check(32'(cc_tdata[71:64]), 32'(mon_e.tag));
        check(32'(cc_tkeep), 32'(mon_e.keep));
        check(32'(cc_tlast), 32'h1);
        if (mon_e.dwc == 11'h001)
          check(cc_tdata[127:96], mon_e.data);
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    $display("unexpected at %0t: run did not finish", $time);
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // every window stored, then read back through an aliased offset
    for (int i = 0; i < 4; i++)
    begin
      at[i] = 64'($random(seed)) & 64'h0000_0000_0000_07FC;
      wr(tgr_pkg::KIND_MEM_WR, i, at[i], $random(seed));
      rd(tgr_pkg::KIND_MEM_RD, i, at[i] | 64'h0000_0004_0000_1800);
    end
    // silent requests: long, unmapped window, I/O while disabled
    req(tgr_pkg::KIND_MEM_WR, HITS[3], at[3], 11'h002, 32'h1234_5678, 3);
    req(tgr_pkg::KIND_MEM_RD, HITS[3], at[3], 11'h002, 32'h0, 1);
    req(tgr_pkg::KIND_MEM_WR, 3'h3, at[3], 11'h001, 32'h1234_5678, 2);
    req(tgr_pkg::KIND_MEM_RD, 3'h5, at[3], 11'h001, 32'h0, 1);
    req(tgr_pkg::KIND_IO_WR, HITS[0], at[0], 11'h001, 32'h1234_5678, 2);
    req(tgr_pkg::KIND_IO_RD, HITS[0], at[0], 11'h001, 32'h0, 1);
    rd(tgr_pkg::KIND_MEM_RD, 3, at[3]);
    rd(tgr_pkg::KIND_MEM_RD, 0, at[0]);
    io_window_en <= 1'b1;
    expq.push_back('{32'h0, 11'h000, tag_q, 4'h7});
    wr(tgr_pkg::KIND_IO_WR, 0, at[0], 32'hA5C3_0F96);
    rd(tgr_pkg::KIND_IO_RD, 0, at[0]);
    // back-to-back traffic with the sink stalling
    slow <= 1'b1;
    repeat (10)
    begin
      k = {$random(seed)} % 4;
      wr(tgr_pkg::KIND_MEM_WR, k, at[k], $random(seed));
      rd(tgr_pkg::KIND_MEM_RD, k, at[k]);
      rd(tgr_pkg::KIND_MEM_RD, 3 - k, at[3-k]);
    end
    n = 0;
    while (expq.size() != 0 && n < 500)
    begin
      n++;
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    close_out();
  end
endmodule // tb_top
